// ### rtl/ibe_defs.vh
// Constants of the two-wire bus protocol engine
`ifndef IBE_DEFS_VH
`define IBE_DEFS_VH

// Register indices on the local register port
`define IBE_ADR_OWN 3'h0
`define IBE_ADR_CTRL 3'h1
`define IBE_ADR_STAT 3'h2
`define IBE_ADR_DATA 3'h3
`define IBE_ADR_DIV 3'h4

// Control register fields
`define IBE_CB_EN 7
`define IBE_CB_IE 6
`define IBE_CB_MS 5
`define IBE_CB_TX 4
`define IBE_CB_TXAK 3
`define IBE_CB_RSTA 2
`define IBE_CB_WOFF 0

// Status register fields
`define IBE_SB_TCF 7
`define IBE_SB_AAS 6
`define IBE_SB_BB 5
`define IBE_SB_AL 4
`define IBE_SB_SRW 2
`define IBE_SB_IF 1
`define IBE_SB_RXAK 0

// Reset values
`define IBE_OWN_RST 8'h00
`define IBE_DIV_RST 8'h1f
`define IBE_BYTE_ZERO 8'h00

// Bit slot of the acknowledge within a byte
`define IBE_ACK_SLOT 4'h8
`define IBE_LAST_DATA 4'h7
// Slot held between START and its SCL fall, which carries no data bit
`define IBE_PRE_SLOT 4'hf

`endif

// ### rtl/ibe_sync.v
// Two-stage synchroniser for inputs arriving from outside the core clock
`timescale 1ns/1ns
module ibe_sync #(
    parameter WIDTH = 2
) (
    core_clk,
    reset_n,
    async_in,
    sync_out
);
    input wire core_clk;
    input wire reset_n;
    input wire [WIDTH-1:0] async_in;
    output wire [WIDTH-1:0] sync_out;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            reg meta_q;
            reg stab_q;
            // Idle bus lines are high, so reset to the released level
            always @(posedge core_clk) begin
                if (!reset_n) begin
                    meta_q <= 1'b1;
                    stab_q <= 1'b1;
                end else begin
                    meta_q <= async_in[gi];
                    stab_q <= meta_q;
                end
            end
            assign sync_out[gi] = stab_q;
        end
    endgenerate
endmodule // ibe_sync

// ### rtl/ibe_engine.v
// Protocol engine of a multi-master two-wire serial bus controller
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "ibe_defs.vh"
module ibe_engine (
    core_clk,
    reset_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    scl_in,
    sda_in,
    scl_out,
    scl_oe,
    sda_out,
    sda_oe,
    wait_mode,
    stop_mode,
    irq
);
    input wire core_clk;
    input wire reset_n;
    input wire [2:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    input wire scl_in;
    input wire sda_in;
    output reg scl_out;
    output reg scl_oe;
    output reg sda_out;
    output reg sda_oe;
    input wire wait_mode;
    input wire stop_mode;
    output reg irq;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam M_IDLE = 3'h0;
    localparam M_START = 3'h1;
    localparam M_HOLD = 3'h2;
    localparam M_RUN = 3'h3;
    localparam M_STOP = 3'h4;
    localparam M_RSTA = 3'h5;

    reg [7:0] own_q;
    reg [7:0] div_q;
    reg [7:0] shift_q;
    reg [7:0] cnt_q;
    reg en_q;
    reg ie_q;
    reg ms_q;
    reg tx_q;
    reg txak_q;
    reg woff_q;
    reg rsta_q;
    reg tcf_q;
    reg aas_q;
    reg bb_q;
    reg al_q;
    reg srw_q;
    reg if_q;
    reg rxak_q;
    reg [3:0] bitn_q;
    reg addr_ph_q;
    reg frame_q;
    reg slv_q;
    reg hold_q;
    reg hi_q;
    reg [2:0] mst_q;
    reg [1:0] ph_q;
    reg scl_p_q;
    reg sda_p_q;
    reg [7:0] rd_mux;

    wire [1:0] lines_s;
    wire scl_s;
    wire sda_s;

    // ****************************************************************
    // Line synchronisers
    // ****************************************************************
    ibe_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({scl_in, sda_in}),
        .sync_out(lines_s)
    );

    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];

    // ****************************************************************
    // Decoded conditions
    // ****************************************************************
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
    // Halted engine freezes the protocol state flops; register-port writes, reg_rdata and irq still update
    wire run = en_q & ~stop_mode & ~(wait_mode & woff_q);
    wire ctrl_wr = reg_wr & (reg_addr == `IBE_ADR_CTRL);
    wire stat_wr = reg_wr & (reg_addr == `IBE_ADR_STAT);
    wire data_wr = reg_wr & (reg_addr == `IBE_ADR_DATA);
    wire data_rd = reg_rd & (reg_addr == `IBE_ADR_DATA);
    wire cnt_done = (cnt_q >= div_q);
    wire master = (mst_q != M_IDLE);
    wire match = (shift_q[7:1] == own_q[7:1]);
    wire is_ack = (bitn_q == `IBE_ACK_SLOT);
    // Who transmits data bits; the address byte always goes out from the master
    wire txing = addr_ph_q ? master : ((master | slv_q) & tx_q);
    wire ack_drive = addr_ph_q ? (~master & match) : ((master | slv_q) & ~tx_q & ~txak_q);
    wire go = hold_q & ((data_wr & tx_q) | (data_rd & ~tx_q));
    // Arbitration is judged only where this master released SDA
    wire lose_arb = (mst_q == M_RUN) & frame_q & scl_rise & ~sda_oe & ~sda_s &
                    (is_ack ? (~addr_ph_q & ~tx_q & txak_q) : txing);
    wire lose_stop = stop_det & master & (mst_q != M_STOP);
    wire lose_busy = (mst_q == M_IDLE) & ms_q & bb_q;
    wire lose_rsta = rsta_q & ~master;
    wire lose = lose_arb | lose_stop | lose_busy | lose_rsta;

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    always @* begin
        case (reg_addr)
            `IBE_ADR_OWN: rd_mux = own_q;
            `IBE_ADR_CTRL: rd_mux = {en_q, ie_q, ms_q, tx_q, txak_q, 2'b00, woff_q};
            `IBE_ADR_STAT: rd_mux = {tcf_q, aas_q, bb_q, al_q, 1'b0, srw_q, if_q, rxak_q};
            `IBE_ADR_DATA: rd_mux = shift_q;
            `IBE_ADR_DIV: rd_mux = div_q;
            default: rd_mux = `IBE_BYTE_ZERO;
        endcase
    end

    // ****************************************************************
    // Registers and protocol engine
    // ****************************************************************
    always @(posedge core_clk) begin
        if (!reset_n) begin
            own_q <= `IBE_OWN_RST;
            div_q <= `IBE_DIV_RST;
            shift_q <= `IBE_BYTE_ZERO;
            cnt_q <= `IBE_BYTE_ZERO;
            en_q <= 1'b0;
            ie_q <= 1'b0;
            ms_q <= 1'b0;
            tx_q <= 1'b0;
            txak_q <= 1'b0;
            woff_q <= 1'b0;
            rsta_q <= 1'b0;
            tcf_q <= 1'b1;
            aas_q <= 1'b0;
            bb_q <= 1'b0;
            al_q <= 1'b0;
            srw_q <= 1'b0;
            if_q <= 1'b0;
            rxak_q <= 1'b1;
            bitn_q <= 4'h0;
            addr_ph_q <= 1'b0;
            frame_q <= 1'b0;
            slv_q <= 1'b0;
            hold_q <= 1'b0;
            hi_q <= 1'b0;
            mst_q <= M_IDLE;
            ph_q <= 2'b00;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            reg_rdata <= `IBE_BYTE_ZERO;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            irq <= 1'b0;
        end else begin
            // Output data stays low: the pins only ever pull down or float
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            reg_rdata <= reg_rd ? rd_mux : `IBE_BYTE_ZERO;
            irq <= if_q & ie_q;
            if (reg_wr && reg_addr == `IBE_ADR_OWN) begin
                own_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `IBE_ADR_DIV) begin
                div_q <= reg_wdata;
            end
            if (ctrl_wr) begin
                en_q <= reg_wdata[`IBE_CB_EN];
                ie_q <= reg_wdata[`IBE_CB_IE];
                ms_q <= reg_wdata[`IBE_CB_MS];
                tx_q <= reg_wdata[`IBE_CB_TX];
                txak_q <= reg_wdata[`IBE_CB_TXAK];
                woff_q <= reg_wdata[`IBE_CB_WOFF];
                rsta_q <= reg_wdata[`IBE_CB_RSTA];
                aas_q <= 1'b0;
            end
            if (stat_wr && reg_wdata[`IBE_SB_AL]) begin
                al_q <= 1'b0;
            end
            if (stat_wr && reg_wdata[`IBE_SB_IF]) begin
                if_q <= 1'b0;
            end
            if (!en_q) begin
                // Disabled: bus let go, protocol state and MS cleared, other settings kept
                mst_q <= M_IDLE;
                ms_q <= 1'b0;
                frame_q <= 1'b0;
                slv_q <= 1'b0;
                hold_q <= 1'b0;
                bb_q <= 1'b0;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                scl_p_q <= 1'b1;
                sda_p_q <= 1'b1;
            end else if (run) begin
                scl_p_q <= scl_s;
                sda_p_q <= sda_s;
                cnt_q <= cnt_done ? cnt_q : cnt_q + 8'h01;
                if (start_det) begin
                    bb_q <= 1'b1;
                    frame_q <= 1'b1;
                    addr_ph_q <= 1'b1;
                    // The SCL fall that completes START wraps this slot to bit zero
                    bitn_q <= `IBE_PRE_SLOT;
                    slv_q <= 1'b0;
                    tcf_q <= 1'b0;
                    if (!master) begin
                        hold_q <= 1'b0;
                    end
                end
                if (stop_det) begin
                    bb_q <= 1'b0;
                    frame_q <= 1'b0;
                    slv_q <= 1'b0;
                    if (!master) begin
                        hold_q <= 1'b0;
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                    end
                end
                // Data is sampled while SCL is high, one bit per clock
                if (scl_rise && frame_q) begin
                    // The acknowledge is kept out of the byte so address and data stay whole
                    if (!is_ack) begin
                        shift_q <= {shift_q[6:0], sda_s};
                    end
                    if (is_ack) begin
                        rxak_q <= sda_s;
                        if (slv_q && tx_q && !addr_ph_q && sda_s) begin
                            slv_q <= 1'b0;
                        end
                    end
                end
                // ************************************************************
                // Master clock generation and bus conditions
                // ************************************************************
                case (mst_q)
                    M_IDLE: begin
                        if (ms_q && !bb_q) begin
                            mst_q <= M_START;
                            cnt_q <= `IBE_BYTE_ZERO;
                            sda_oe <= 1'b1;
                        end
                    end
                    M_START: begin
                        if (cnt_done) begin
                            scl_oe <= 1'b1;
                            hold_q <= 1'b1;
                            mst_q <= M_HOLD;
                        end
                    end
                    M_HOLD: begin
                        if (!ms_q) begin
                            // SCL is low here, so pulling SDA low is no condition
                            mst_q <= M_STOP;
                            ph_q <= 2'b00;
                            cnt_q <= `IBE_BYTE_ZERO;
                            sda_oe <= 1'b1;
                        end else if (rsta_q) begin
                            rsta_q <= 1'b0;
                            mst_q <= M_RSTA;
                            ph_q <= 2'b00;
                            cnt_q <= `IBE_BYTE_ZERO;
                            sda_oe <= 1'b0;
                        end
                    end
                    M_RUN: begin
                        if (scl_fall) begin
                            hi_q <= 1'b0;
                            cnt_q <= `IBE_BYTE_ZERO;
                            scl_oe <= 1'b1;
                        end else if (!hi_q) begin
                            if (scl_oe) begin
                                if (cnt_done) begin
                                    scl_oe <= 1'b0;
                                end
                            end else if (scl_s) begin
                                // Others may still hold SCL low: wait for the real line
                                hi_q <= 1'b1;
                                cnt_q <= `IBE_BYTE_ZERO;
                            end
                        end else if (cnt_done) begin
                            scl_oe <= 1'b1;
                        end
                    end
                    M_STOP: begin
                        case (ph_q)
                            2'b00: begin
                                if (cnt_done) begin
                                    scl_oe <= 1'b0;
                                    ph_q <= 2'b01;
                                end
                            end
                            2'b01: begin
                                if (scl_s) begin
                                    cnt_q <= `IBE_BYTE_ZERO;
                                    ph_q <= 2'b10;
                                end
                            end
                            default: begin
                                if (cnt_done) begin
                                    sda_oe <= 1'b0;
                                    hold_q <= 1'b0;
                                    mst_q <= M_IDLE;
                                end
                            end
                        endcase
                    end
                    M_RSTA: begin
                        case (ph_q)
                            2'b00: begin
                                if (cnt_done) begin
                                    scl_oe <= 1'b0;
                                    ph_q <= 2'b01;
                                end
                            end
                            2'b01: begin
                                if (scl_s) begin
                                    cnt_q <= `IBE_BYTE_ZERO;
                                    ph_q <= 2'b10;
                                end
                            end
                            2'b10: begin
                                if (cnt_done) begin
                                    sda_oe <= 1'b1;
                                    cnt_q <= `IBE_BYTE_ZERO;
                                    ph_q <= 2'b11;
                                end
                            end
                            default: begin
                                if (cnt_done) begin
                                    scl_oe <= 1'b1;
                                    mst_q <= M_HOLD;
                                end
                            end
                        endcase
                    end
                    default: begin
                        mst_q <= M_IDLE;
                    end
                endcase
                // ************************************************************
                // Bit and byte sequencing on the falling SCL edge
                // ************************************************************
                if (scl_fall && frame_q) begin
                    if (is_ack) begin
                        bitn_q <= 4'h0;
                        addr_ph_q <= 1'b0;
                        sda_oe <= 1'b0;
                        if (master || slv_q || (addr_ph_q && match)) begin
                            tcf_q <= 1'b1;
                            if_q <= 1'b1;
                        end
                        if (addr_ph_q && !master && match) begin
                            aas_q <= 1'b1;
                            srw_q <= shift_q[0];
                            slv_q <= 1'b1;
                            hold_q <= 1'b1;
                            scl_oe <= 1'b1;
                        end else if (master || slv_q) begin
                            hold_q <= 1'b1;
                            scl_oe <= 1'b1;
                            if (master) begin
                                mst_q <= M_HOLD;
                            end
                        end
                    end else begin
                        bitn_q <= bitn_q + 4'h1;
                        if (bitn_q == `IBE_LAST_DATA) begin
                            sda_oe <= ack_drive;
                        end else begin
                            sda_oe <= txing & ~shift_q[7];
                        end
                    end
                end
                // A data-port write when transmitting, or a data-port read when receiving, releases a held byte boundary
                if (go) begin
                    hold_q <= 1'b0;
                    tcf_q <= 1'b0;
                    if (tx_q) begin
                        shift_q <= reg_wdata;
                        sda_oe <= ~reg_wdata[7];
                    end else begin
                        sda_oe <= 1'b0;
                    end
                    if (master) begin
                        mst_q <= M_RUN;
                        hi_q <= 1'b0;
                        cnt_q <= `IBE_BYTE_ZERO;
                    end else begin
                        scl_oe <= 1'b0;
                    end
                end
                if (lose) begin
                    al_q <= 1'b1;
                    if_q <= 1'b1;
                    ms_q <= 1'b0;
                    rsta_q <= 1'b0;
                    mst_q <= M_IDLE;
                    if (master) begin
                        // No STOP is formed: both lines simply let go
                        sda_oe <= 1'b0;
                        scl_oe <= 1'b0;
                        hold_q <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // ibe_engine

// ### verification/ibe_engine_asserts.sv
// Port-level assertions for the two-wire protocol engine
`timescale 1ns/1ns
`include "ibe_defs.vh"
module ibe_engine_asserts (
    input wire core_clk,
    input wire reset_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire scl_in,
    input wire sda_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_out,
    input wire sda_oe,
    input wire wait_mode,
    input wire stop_mode,
    input wire irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // The request may only drop one or two cycles after a flag clear or a control write
    wire clr = reg_wr && (reg_addr == `IBE_ADR_CTRL ||
        (reg_addr == `IBE_ADR_STAT && reg_wdata[`IBE_SB_IF]));
    property p_out_zero; !scl_out && !sda_out; endproperty
    a_out_zero: assert property (p_out_zero) else $error("line data not zero");
    property p_reset_idle; disable iff (1'b0) !reset_n |=> !scl_oe && !sda_oe && !irq; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("lines held in reset");
    property p_start_free; $rose(sda_oe) && scl_in |-> $past(sda_in, 2); endproperty
    a_start_free: assert property (p_start_free) else $error("start on held bus");
    // Long outside low phases are someone else's stretch, never our own low count
    property p_scl_wait; (!scl_oe && !scl_in) [*8] |=> !scl_oe; endproperty
    a_scl_wait: assert property (p_scl_wait) else $error("clock pulled before high");
    property p_sda_hold; (!scl_oe && !scl_in) [*8] |=> $stable(sda_oe); endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("data moved in wait");
    property p_irq_hold; irq && !clr && !$past(clr) |=> irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped unasked");
    property p_ie_off;
        reg_wr && reg_addr == `IBE_ADR_CTRL && !reg_wdata[`IBE_CB_IE] |=> ##1 !irq;
    endproperty
    a_ie_off: assert property (p_ie_off) else $error("request while disabled");
    property p_stop_freeze;
        stop_mode && $past(stop_mode) && !$past(reg_wr) |-> $stable(scl_oe) && $stable(sda_oe);
    endproperty
    a_stop_freeze: assert property (p_stop_freeze) else $error("lines moved in stop");
    c_irq: cover property ($rose(irq));
    c_start: cover property ($rose(sda_oe) && scl_in);
    c_stretch: cover property ((!scl_oe && !scl_in) [*8]);
endmodule // ibe_engine_asserts

bind ibe_engine ibe_engine_asserts u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
    .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .wait_mode(wait_mode), .stop_mode(stop_mode), .irq(irq));

// ### verification/ibe_bus_model.sv
// Behavioural slave on the two-wire bus: acks its address, may stretch SCL
`timescale 1ns/1ns
module ibe_bus_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire scl,
    input wire sda,
    input wire stretch,
    output logic scl_pull,
    output logic sda_pull,
    output logic [7:0] rx_byte
);
    logic [3:0] bits = 4'h0;
    logic [7:0] sh = 8'h00;
    logic first = 1'b0;
    logic sel = 1'b0;
    initial {scl_pull, sda_pull, rx_byte} = 10'h000;
    always @(negedge sda) if (scl) begin
        bits = 4'h0;
        first = 1'b1;
    end
    always @(posedge sda) if (scl) sel = 1'b0;
    always @(posedge scl) begin
        sh = bits < 4'h8 ? {sh[6:0], sda} : sh;
        bits = bits + 4'h1;
    end
    always @(negedge scl) begin
        if (bits == 4'h8) begin
            sel = first ? sh[7:1] == ADDR : sel;
            sda_pull = sel;
        end
        if (bits == 4'h9) begin
            sda_pull = 1'b0;
            if (sel && !first) rx_byte = sh;
            first = 1'b0;
            bits = 4'h0;
            // Holding the clock only after a whole byte keeps the device's own count honest
            if (stretch) begin
                scl_pull = 1'b1;
                #2000 scl_pull = 1'b0;
            end
        end
    end
endmodule // ibe_bus_model

// ### verification/tb_ibe_engine.sv
// Self-checking bench for the two-wire protocol engine
`timescale 1ns/1ns
`include "ibe_defs.vh"
module tb_ibe_engine;
    logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, wait_mode = 0, stop_mode = 0;
    logic tb_scl = 0, tb_sda = 0, stretch = 0, ack = 0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, d;
    wire [7:0] reg_rdata, rx_byte;
    wire scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda;
    wire scl = !(scl_oe || m_scl || tb_scl);
    wire sda = !(sda_oe || m_sda || tb_sda);
    int fail_count = 0, comparisons = 0;
    // Row: address, reset value, value written, value read back
    logic [31:0] rows [5] = '{32'h00001010, 32'h01008080, 32'h0281ff81, 32'h041f0101, 32'h0700ff00};
    ibe_engine DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
        .sda_oe(sda_oe), .wait_mode(wait_mode), .stop_mode(stop_mode), .irq(irq));
    ibe_bus_model u_slv (.scl(scl), .sda(sda), .stretch(stretch), .scl_pull(m_scl),
        .sda_pull(m_sda), .rx_byte(rx_byte));
    initial forever #20 core_clk = !core_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Polls status under a bound, then compares the masked bits
    task automatic st(input logic [7:0] m, input logic [7:0] v);
        int i;
        rd(`IBE_ADR_STAT);
        for (i = 0; i < 2000 && (d & m) !== v; i++) rd(`IBE_ADR_STAT);
        chk(d & m, v);
    endtask
    // Outside master, one bit every 320 ns, ack sampled in the ninth high phase
    task automatic tbm(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            tb_sda <= !b[i];
            cyc(2);
            tb_scl <= 1'b0;
            cyc(4);
            tb_scl <= 1'b1;
            cyc(2);
        end
        tb_sda <= 1'b0;
        cyc(4);
        tb_scl <= 1'b0;
        cyc(3);
        ack = sda;
        cyc(1);
        tb_scl <= 1'b1;
        cyc(4);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #3000000;
        fail_count++;
        give_verdict();
    end
    initial begin
        cyc(16);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i][26:24]);
            chk(d, rows[i][23:16]);
            wr(rows[i][26:24], rows[i][15:8]);
            rd(rows[i][26:24]);
            chk(d, rows[i][7:0]);
        end
        wr(`IBE_ADR_CTRL, 8'hf0);
        st(8'h20, 8'h20);
        wr(`IBE_ADR_DATA, 8'h54);
        st(8'h83, 8'h82);
        cyc(1);
        #1;
        chk(irq, 1'b1);
        wr(`IBE_ADR_STAT, 8'h00);
        cyc(2);
        #1;
        chk(irq, 1'b1);
        wr(`IBE_ADR_STAT, 8'h02);
        cyc(2);
        #1;
        chk(irq, 1'b0);
        stretch <= 1'b1;
        wr(`IBE_ADR_DATA, 8'ha5);
        st(8'h82, 8'h82);
        chk(rx_byte, 8'ha5);
        wr(`IBE_ADR_STAT, 8'h02);
        // Stop is asked while the slave still stretches, so the master must wait
        wr(`IBE_ADR_CTRL, 8'hd0);
        st(8'h20, 8'h00);
        stretch <= 1'b0;
        wr(`IBE_ADR_CTRL, 8'hf0);
        st(8'h20, 8'h20);
        wr(`IBE_ADR_DATA, 8'h56);
        st(8'h83, 8'h83);
        wr(`IBE_ADR_STAT, 8'h02);
        wr(`IBE_ADR_CTRL, 8'hd0);
        st(8'h20, 8'h00);
        tb_sda <= 1'b1;
        st(8'h20, 8'h20);
        wr(`IBE_ADR_CTRL, 8'hf0);
        st(8'h12, 8'h12);
        chk(sda_oe, 1'b0);
        wr(`IBE_ADR_STAT, 8'h12);
        tb_scl <= 1'b1;
        cyc(4);
        tbm(8'h10);
        chk(ack, 1'b0);
        st(8'h44, 8'h40);
        wr(`IBE_ADR_CTRL, 8'hc0);
        st(8'h40, 8'h00);
        stop_mode <= 1'b1;
        wait_mode <= 1'b1;
        rd(`IBE_ADR_OWN);
        chk(d, 8'h10);
        stop_mode <= 1'b0;
        wait_mode <= 1'b0;
        rd(`IBE_ADR_DATA);
        tb_sda <= 1'b1;
        cyc(4);
        tb_scl <= 1'b0;
        cyc(6);
        tb_sda <= 1'b0;
        st(8'h20, 8'h00);
        give_verdict();
    end
endmodule // tb_ibe_engine
